// ===== rtl/charger_supervisor.sv
// Charger status, interrupt, wake pulse, fault timer and thermistor control
// Assumes comparator levels synchronous to i_clk and an APB master on the bus
// Summary of operation
// - Writing zero to the interrupt flag releases the interrupt pin high.
// - With the droop mask set, droop changes do not raise the interrupt.
// - Unit enabled and thermistor above 90% of bias sets battery-absent and flag.
// - Power-good sets above battery plus upper offset, clears below lower offset, on undervoltage or overvoltage.
// - End-of-charge reads one when done or recharging; setting it raises the flag.
// - A plug-in held 40 ms gives one 70 ms high wake pulse.
// - No new wake pulses while enabled; a running pulse completes.
// - Suspend bit set puts the charger in suspend, indicator released.
// - Current code maps 0.1 A steps up to 1.2 A; default 0.5 A.
// - Fast charge past fault time flashes indicator at 4 Hz, trickle current.
// - Replug, enable toggle, suspend change, battery removal or overvoltage clear fault.
// - Fault time scales inversely with charge current, halving current doubles it.
// - Voltage target changes in cool and warm bands unless disabled per side.
// - Current level changes in cool and warm bands unless disabled per side.
// - Thermistor out of range suspends charging and freezes the safety timer.
// - Temperature suspension flashes the indicator at 0.5 Hz.
// - Thermistor bias on while charging or while the unit is enabled.
// - Range select picks thresholds for 100 kilohm or 10 kilohm thermistors.
// - Full-current band lies between 32%/52% or 35%/64% of bias.
// - Any toggle of the listed status bits, except charge-running rising and masked droop changes, sets the interrupt flag.
// - The interrupt pin is open drain, driven from the interrupt flag.
//
// Added by the designer: register access over APB and the placing of the registers.
`default_nettype none
`include "charger_defs.svh"
module charger_supervisor #(
  parameter int MS_CYCLES = `MS_TICK_CYCLES,
  parameter logic [31:0] FAULT_BUDGET = `FAULT_BUDGET
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire charger_pkg::apb_req_type i_apb,
  output charger_pkg::apb_rsp_type o_apb,
  // Supply and battery levels
  input wire logic i_pmu_en,
  input wire logic i_vin_uvlo,
  input wire logic i_vin_above_os_h,
  input wire logic i_vin_above_os_l,
  input wire logic i_vin_ovp,
  input wire logic i_vin_plug,
  input wire logic i_bat_plug,
  input wire logic [6:0] i_ts_ratio,
  // Charger core levels
  input wire logic i_charging,
  input wire logic i_fast_phase,
  input wire logic i_charge_done,
  input wire logic i_recharge,
  input wire logic i_thermal_reg,
  input wire logic i_input_droop_limit,
  // Pins
  output logic o_irq_o,
  output logic o_irq_oe,
  output logic o_chg_o,
  output logic o_chg_oe,
  output logic o_wake,
  output logic o_bias_en,
  // Charger core controls
  output logic [3:0] o_cc_code,
  output logic o_cc_halve,
  output logic o_cv_reduce,
  output logic o_charge_en,
  output logic o_trickle
);
  import charger_pkg::*;
  localparam int ACCESS_WAIT = 2;
  // ----------------------------------------
  // Millisecond tick
  // ----------------------------------------
  logic [19:0] div_q;
  logic tick_q;
  wire div_end = (div_q == 20'(MS_CYCLES - 1));
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div_q <= 20'h00000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_end ? 20'h00000 : div_q + 20'h00001;
      tick_q <= div_end;
    end
  end
  // ----------------------------------------
  // Register bus slave
  // ----------------------------------------
  logic [10:0] ctrl_q;
  logic irq_q;
  logic battery_absent_q, input_power_ok_q, eoc_q, fault_q, droop_q, thr_q, chgrun_q;
  ts_band_type band_q;
  wire setup = i_apb.psel && !i_apb.penable && !o_apb.pready;
  wire wr_done = i_apb.psel && i_apb.penable && o_apb.pready && i_apb.pwrite;
  wire hit_ctrl = (i_apb.paddr == `OFS_CTRL);
  wire hit_status = (i_apb.paddr == `OFS_STATUS);
  wire hit_effect = (i_apb.paddr == `OFS_EFFECT);
  wire wr_ctrl = wr_done && hit_ctrl;
  wire irq_clear = wr_done && hit_status && !i_apb.pwdata[`ST_IRQ];
  wire [10:0] status_word = {band_q, droop_q, chgrun_q, fault_q, thr_q, eoc_q, input_power_ok_q,
                             battery_absent_q, irq_q};
  wire [31:0] effect_word = {25'h0000000, o_charge_en, o_cv_reduce, o_cc_halve, o_cc_code};
  wire [31:0] rd_mux = hit_ctrl ? {21'h000000, ctrl_q} :
                       hit_status ? {21'h000000, status_word} :
                       hit_effect ? effect_word : 32'h00000000;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_apb <= '0;
    end else begin
      o_apb.pready <= setup;
      o_apb.pslverr <= setup && !(hit_ctrl || hit_status || hit_effect);
      o_apb.prdata <= setup ? rd_mux : 32'h00000000;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= i_apb.pwdata[10:0];
    end
  end
  wire suspend = ctrl_q[`CTRL_SUSPEND];
  wire range_hi = ctrl_q[`CTRL_RANGE];
  wire [3:0] code = ctrl_q[`CTRL_CODE_MSB:`CTRL_CODE_LSB];
  // ----------------------------------------
  // Thermistor bands
  // ----------------------------------------
  wire [6:0] cold_th = range_hi ? `PCT_COLD_HI : `PCT_COLD_LO;
  wire [6:0] full_lo = range_hi ? `PCT_FULL_LO_H : `PCT_FULL_LO_L;
  wire [6:0] full_hi = range_hi ? `PCT_FULL_HI_H : `PCT_FULL_HI_L;
  wire battery_absent_d = i_pmu_en && (i_ts_ratio > `PCT_BATTERY_ABSENT);
  wire ts_ok = (i_ts_ratio < cold_th) && (i_ts_ratio > `PCT_HOT) && !battery_absent_d;
  wire ts_cool = ts_ok && (i_ts_ratio > full_hi);
  wire ts_warm = ts_ok && (i_ts_ratio < full_lo);
  wire ts_band_en = o_bias_en && ts_ok;
  ts_band_type band_d;
  assign band_d = !ts_band_en ? BAND_OUT : ts_cool ? BAND_COOL : ts_warm ? BAND_WARM : BAND_FULL;
  wire halve = (ts_cool && !ctrl_q[`CTRL_COLD_CC_DIS]) ||
               (ts_warm && !ctrl_q[`CTRL_HOT_CC_DIS]);
  wire cv_red = (ts_cool && !ctrl_q[`CTRL_COLD_CV_DIS]) ||
                (ts_warm && !ctrl_q[`CTRL_HOT_CV_DIS]);
  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  wire input_power_ok_set = !i_vin_uvlo && !i_vin_ovp && i_vin_above_os_h;
  wire input_power_ok_clr = i_vin_uvlo || i_vin_ovp || !i_vin_above_os_l;
  wire input_power_ok_d = input_power_ok_set || (input_power_ok_q && !input_power_ok_clr);
  wire eoc_d = i_charge_done || i_recharge;
  wire chgrun_d = o_charge_en;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      battery_absent_q <= 1'b0;
      input_power_ok_q <= 1'b0;
      eoc_q <= 1'b0;
      thr_q <= 1'b0;
      droop_q <= 1'b0;
      chgrun_q <= 1'b0;
      band_q <= BAND_OUT;
    end else begin
      battery_absent_q <= battery_absent_d;
      input_power_ok_q <= input_power_ok_d;
      eoc_q <= eoc_d;
      thr_q <= i_thermal_reg;
      droop_q <= i_input_droop_limit;
      chgrun_q <= chgrun_d;
      band_q <= band_d;
    end
  end
  // ----------------------------------------
  // Interrupt flag and pin
  // ----------------------------------------
  wire [6:0] cur_bits = {input_power_ok_q, eoc_q, thr_q, fault_q, battery_absent_q, chgrun_q, droop_q};
  logic [6:0] prev_q;
  ts_band_type band_prev_q;
  wire [6:0] toggled = cur_bits ^ prev_q;
  wire droop_ev = toggled[0] && !ctrl_q[`CTRL_DROOP_MASK];
  wire chgrun_ev = prev_q[1] && !chgrun_q;
  wire irq_event = (|toggled[6:2]) || chgrun_ev || droop_ev || (band_q != band_prev_q);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prev_q <= 7'h00;
      band_prev_q <= BAND_OUT;
      irq_q <= 1'b0;
    end else begin
      prev_q <= cur_bits;
      band_prev_q <= band_q;
      if (irq_event) begin
        irq_q <= 1'b1;
      end else if (irq_clear) begin
        irq_q <= 1'b0;
      end
    end
  end
  assign o_irq_o = 1'b0;
  assign o_irq_oe = irq_q;
  // ----------------------------------------
  // Wake pulse
  // ----------------------------------------
  wire plug = i_vin_plug || i_bat_plug;
  logic armed_q, wake_q, deg_hit, width_hit;
  tick_counter #(.W(10)) u_deglitch (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(!plug),
    .i_tick(tick_q),
    .i_limit(`DEGLITCH_MS),
    .o_hit(deg_hit)
  );
  tick_counter #(.W(10)) u_width (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(!wake_q),
    .i_tick(tick_q),
    .i_limit(`WAKE_MS),
    .o_hit(width_hit)
  );
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      armed_q <= 1'b1;
      wake_q <= 1'b0;
    end else begin
      armed_q <= !plug || (armed_q && !deg_hit);
      if (wake_q) begin
        wake_q <= !width_hit;
      end else begin
        wake_q <= plug && deg_hit && armed_q && !i_pmu_en;
      end
    end
  end
  assign o_wake = wake_q;
  // ----------------------------------------
  // Fault timer
  // ----------------------------------------
  logic [31:0] acc_q;
  logic en_prev_q, susp_prev_q, vin_prev_q, ovp_prev_q, battery_absent_prev_q;
  wire fault_release = (i_vin_plug && !vin_prev_q) || (i_pmu_en != en_prev_q) ||
                       (suspend != susp_prev_q) || (battery_absent_q && !battery_absent_prev_q) ||
                       (i_vin_ovp && !ovp_prev_q);
  wire [4:0] code_units = {1'b0, o_cc_code} + 5'h01;
  wire [31:0] step = halve ? {27'h0000000, code_units} : {26'h0000000, code_units, 1'b0};
  wire timing = i_fast_phase && o_charge_en && ts_ok;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      en_prev_q <= 1'b0;
      susp_prev_q <= 1'b0;
      vin_prev_q <= 1'b0;
      ovp_prev_q <= 1'b0;
      battery_absent_prev_q <= 1'b0;
    end else begin
      en_prev_q <= i_pmu_en;
      susp_prev_q <= suspend;
      vin_prev_q <= i_vin_plug;
      ovp_prev_q <= i_vin_ovp;
      battery_absent_prev_q <= battery_absent_q;
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst || fault_release) begin
      acc_q <= 32'h00000000;
      fault_q <= 1'b0;
    end else if (tick_q && timing) begin
      acc_q <= acc_q + step;
      fault_q <= (acc_q + step) >= FAULT_BUDGET;
    end
  end
  // ----------------------------------------
  // Charge control outputs
  // ----------------------------------------
  wire run = i_charging && !suspend && !fault_q && ts_ok;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cc_code <= 4'h4;
      o_cc_halve <= 1'b0;
      o_cv_reduce <= 1'b0;
      o_charge_en <= 1'b0;
      o_trickle <= 1'b0;
      o_bias_en <= 1'b0;
    end else begin
      o_cc_code <= (code > `CODE_MAX) ? `CODE_MAX : code;
      o_cc_halve <= halve;
      o_cv_reduce <= cv_red;
      o_charge_en <= run;
      o_trickle <= fault_q;
      o_bias_en <= i_charging || i_pmu_en;
    end
  end
  // ----------------------------------------
  // Charge indicator
  // ----------------------------------------
  wire temp_susp = i_charging && !ts_ok && !fault_q && !suspend;
  wire flashing = !suspend && (fault_q || temp_susp);
  logic blink_q, flash_hit;
  tick_counter #(.W(10)) u_flash (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clr(flash_hit || !flashing),
    .i_tick(tick_q),
    .i_limit(fault_q ? `FLASH_FAULT_MS : `FLASH_TEMP_MS),
    .o_hit(flash_hit)
  );
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      blink_q <= 1'b0;
      o_chg_oe <= 1'b0;
    end else begin
      blink_q <= flashing && (blink_q ^ flash_hit);
      if (suspend) begin
        o_chg_oe <= 1'b0;
      end else if (flashing) begin
        o_chg_oe <= blink_q;
      end else begin
        o_chg_oe <= i_charging && !eoc_q;
      end
    end
  end
  assign o_chg_o = 1'b0;
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic [6:0] wake_ms_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_wake) begin
      wake_ms_q <= 7'h00;
    end else if (tick_q) begin
      wake_ms_q <= wake_ms_q + 7'h01;
    end
  end
  irq_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    irq_clear && !irq_event |=> !o_irq_oe) else $error("interrupt pin not released");
  droop_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !irq_q && ctrl_q[`CTRL_DROOP_MASK] && toggled == 7'h01 && band_q == band_prev_q
    |=> !irq_q) else $error("masked droop raised interrupt");
  battery_absent_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(battery_absent_q) |=> irq_q) else $error("battery absent did not raise flag");
  input_power_ok_range_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_vin_ovp || i_vin_uvlo |=> !input_power_ok_q) else $error("power good under fault");
  eoc_flag_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(eoc_q) |=> irq_q) else $error("end of charge did not raise flag");
  wake_width_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_wake) |-> $past(wake_ms_q) == 7'h46) else $error("wake pulse width wrong");
  wake_mask_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_wake) |-> !$past(i_pmu_en)) else $error("wake pulse while enabled");
  suspend_chg_a: assert property (@(posedge i_clk) disable iff (i_rst)
    suspend |=> !o_chg_oe && !o_charge_en) else $error("indicator driven in suspend");
  code_clamp_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_cc_code <= `CODE_MAX) else $error("current code above limit");
  bias_en_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pmu_en |=> o_bias_en) else $error("bias off while enabled");
  bus_ready_a: assert property (@(posedge i_clk) disable iff (i_rst)
    setup |-> ##[1:ACCESS_WAIT] o_apb.pready) else $error("bus answer late");
  wake_seen_c: cover property (@(posedge i_clk) disable iff (i_rst) $fell(o_wake));
  fault_seen_c: cover property (@(posedge i_clk) disable iff (i_rst) $rose(fault_q));
  irq_clear_c: cover property (@(posedge i_clk) disable iff (i_rst) irq_q ##1 !irq_q);
endmodule : charger_supervisor
`default_nettype wire

// ===== rtl/charger_defs.svh
// Offsets, field positions, reset values and timing counts of the charger supervisor
// Assumes inclusion by bare name from every design file that needs them
`ifndef CHARGER_DEFS_SVH
`define CHARGER_DEFS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_EFFECT 12'h008
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_CODE_LSB 0
`define CTRL_CODE_MSB 3
`define CTRL_SUSPEND 4
`define CTRL_RANGE 5
`define CTRL_DROOP_MASK 6
`define CTRL_HOT_CV_DIS 7
`define CTRL_COLD_CV_DIS 8
`define CTRL_HOT_CC_DIS 9
`define CTRL_COLD_CC_DIS 10
`define CTRL_RESET 11'h004
// ----------------------------------------
// Status register fields
// ----------------------------------------
`define ST_IRQ 0
`define ST_BATTERY_ABSENT 1
`define ST_INPUT_POWER_OK 2
`define ST_EOC 3
`define ST_THR 4
`define ST_SAFE 5
`define ST_CHGRUN 6
`define ST_DROOP 7
`define ST_METER_LSB 8
`define ST_METER_MSB 10
// ----------------------------------------
// Thermistor ratios in percent of bias
// ----------------------------------------
`define PCT_BATTERY_ABSENT 7'h5A
`define PCT_COLD_HI 7'h4A
`define PCT_COLD_LO 7'h3C
`define PCT_HOT 7'h1C
`define PCT_FULL_LO_L 7'h20
`define PCT_FULL_HI_L 7'h34
`define PCT_FULL_LO_H 7'h23
`define PCT_FULL_HI_H 7'h40
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 8
`define MS_TICK_NS 1000000
`define MS_TICK_CYCLES (`MS_TICK_NS / `CLK_PERIOD_NS)
`define DEGLITCH_MS 10'h028
`define WAKE_MS 10'h046
`define FLASH_FAULT_MS 10'h07D
`define FLASH_TEMP_MS 10'h3E8
`define CODE_MAX 4'hB
`define FAULT_BUDGET 32'h0112A880
`endif

// ===== rtl/charger_pkg.sv
// Types shared by the charger supervisor files
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package charger_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;
  typedef enum logic [2:0] {
    BAND_OUT = 3'b000,
    BAND_COOL = 3'b001,
    BAND_FULL = 3'b010,
    BAND_WARM = 3'b011
  } ts_band_type;
endpackage : charger_pkg
`default_nettype wire

// ===== rtl/tick_counter.sv
// Saturating counter of enable ticks with a run-time limit
// Assumes a synchronous active-high reset and a one-cycle tick enable
`default_nettype none
module tick_counter #(
  parameter int W = 10
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_clr,
  input wire logic i_tick,
  input wire logic [W-1:0] i_limit,
  // Result
  output logic o_hit
);
  logic [W-1:0] count_q;
  assign o_hit = (count_q == i_limit);
  always_ff @(posedge i_clk) begin
    if (i_rst || i_clr) begin
      count_q <= '0;
    end else if (i_tick && !o_hit) begin
      count_q <= count_q + 1'b1;
    end
  end
endmodule : tick_counter
`default_nettype wire

// ===== tb/charger_far_side.sv
// Far-side model: battery pack thermistor divider and pack plug level
// Assumes the bench commands the thermistor ratio and pack presence
`default_nettype none
module charger_far_side (
  // Commands
  input wire logic i_bias_en,
  input wire logic i_pack_in,
  input wire logic [6:0] i_ratio,
  // Pack levels
  output logic [6:0] o_ts_ratio,
  output logic o_bat_plug
);
  timeunit 1ns;
  timeprecision 1ps;
  // Unbiased divider reads zero; an absent pack lets the pin rise to bias
  assign o_ts_ratio = !i_bias_en ? 7'h00 : (!i_pack_in ? 7'h64 : i_ratio);
  assign o_bat_plug = i_pack_in;
endmodule : charger_far_side
`default_nettype wire

// ===== tb/charger_supervisor_tb.sv
// Self-checking bench for the charger supervisor
// Assumes the package, the design files and the far-side model compile first
`default_nettype none
module charger_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import charger_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  typedef struct {logic rd; logic [31:0] data; logic err;} note_type;
  localparam int ms_cycles = 10;
  localparam logic [20:0] band_tbl [9] = '{
    {12'h004, 7'h37, 2'b11}, {12'h404, 7'h37, 2'b01}, {12'h104, 7'h37, 2'b10},
    {12'h004, 7'h1E, 2'b11}, {12'h204, 7'h1E, 2'b01}, {12'h084, 7'h1E, 2'b10},
    {12'h024, 7'h37, 2'b00}, {12'h024, 7'h21, 2'b11}, {12'h004, 7'h21, 2'b00}};
  logic i_clk, i_rst, pmu_en, uvlo, os_h, os_l, ovp, vin_plug, pack_in, charging, fast;
  logic done, rech, thr, droop, bat_plug, irq_o, irq_oe, chg_o, chg_oe, wake, bias_en;
  logic halve, cv_red, chg_en, trickle;
  logic [6:0] ratio_cmd, ts_ratio;
  logic [3:0] cc_code;
  apb_req_type req;
  apb_rsp_type rsp;
  note_type notes [$];
  int n_fail = 0;
  int comparisons = 0;
  int seed, t, c;
  charger_far_side u_far (.i_bias_en(bias_en), .i_pack_in(pack_in), .i_ratio(ratio_cmd),
    .o_ts_ratio(ts_ratio), .o_bat_plug(bat_plug));
  charger_supervisor #(.MS_CYCLES(ms_cycles), .FAULT_BUDGET(32'h00000032)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_apb(req), .o_apb(rsp), .i_pmu_en(pmu_en),
    .i_vin_uvlo(uvlo), .i_vin_above_os_h(os_h), .i_vin_above_os_l(os_l), .i_vin_ovp(ovp),
    .i_vin_plug(vin_plug), .i_bat_plug(bat_plug), .i_ts_ratio(ts_ratio),
    .i_charging(charging), .i_fast_phase(fast), .i_charge_done(done), .i_recharge(rech),
    .i_thermal_reg(thr), .i_input_droop_limit(droop), .o_irq_o(irq_o), .o_irq_oe(irq_oe),
    .o_chg_o(chg_o), .o_chg_oe(chg_oe), .o_wake(wake), .o_bias_en(bias_en),
    .o_cc_code(cc_code), .o_cc_halve(halve), .o_cv_reduce(cv_red), .o_charge_en(chg_en),
    .o_trickle(trickle));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: pin value %h, expected %h", $time, got, exp);
    end
  endtask : cmp_pin
  task automatic cmp_bus(input note_type n, input apb_rsp_type r);
    comparisons++;
    if (r.pslverr !== n.err || (n.rd && r.prdata !== n.data)) begin
      n_fail++;
      $display("Error at %0t: bus gave %h/%b, expected %h/%b", $time, r.prdata, r.pslverr,
        n.data, n.err);
    end
  endtask : cmp_bus
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp = 32'h0, input logic err = 1'b0);
    notes.push_back('{!wr, exp, err});
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge i_clk);
    end while (rsp.pready !== 1'b1);
    req <= '0;
    @(posedge i_clk);
  endtask : apb
  task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int n);
    n = 0;
    while (s !== lvl && n < lim) begin
      @(posedge i_clk);
      n++;
    end
  endtask : wait_lvl
  task automatic clr_irq;
    repeat (4) @(posedge i_clk);
    apb(1'b1, 12'h004, 32'h0);
    repeat (2) @(posedge i_clk);
  endtask : clr_irq
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    if (rsp.pready === 1'b1) cmp_bus(notes.pop_front(), rsp);
  end
  initial begin
    #400us;
    n_fail++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    seed = 59;
    i_rst = 1'b1;
    req = '0;
    {pmu_en, uvlo, ovp, vin_plug, pack_in, charging, fast, done, rech, thr, droop} = '0;
    {os_h, os_l} = 2'b11;
    ratio_cmd = 7'h2D;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    cmp_pin(32'({cc_code, bias_en, wake, trickle}), 32'h20);
    apb(1'b0, 12'h000, 32'h0, 32'h4);
    apb(1'b1, 12'h010, 32'hFFF, 32'h0, 1'b1);
    apb(1'b0, 12'h00C, 32'h0, 32'h0, 1'b1);
    apb(1'b0, 12'h000, 32'h0, 32'h4);
    for (int i = 0; i < 20; i++) begin
      c = (i < 16) ? i : ($random(seed) & 15);
      apb(1'b1, 12'h000, 32'(c));
      apb(1'b0, 12'h000, 32'h0, 32'(c));
      cmp_pin(32'(cc_code), (c > 11) ? 32'hB : 32'(c));
    end
    apb(1'b1, 12'h000, 32'h4);
    $display("Map and current code tests done");
    clr_irq();
    cmp_pin(32'({irq_oe, irq_o, chg_o}), 32'h0);
    apb(1'b0, 12'h004, 32'h0, 32'h4);
    ovp <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmp_pin(32'(irq_oe), 32'h1);
    apb(1'b0, 12'h004, 32'h0, 32'h1);
    clr_irq();
    cmp_pin(32'(irq_oe), 32'h0);
    ovp <= 1'b0;
    clr_irq();
    uvlo <= 1'b1;
    repeat (4) @(posedge i_clk);
    apb(1'b0, 12'h004, 32'h0, 32'h1);
    {uvlo, os_h, os_l} <= 3'b000;
    repeat (11) @(posedge i_clk);
    apb(1'b0, 12'h004, 32'h0, 32'h1);
    {os_h, os_l} <= 2'b11;
    clr_irq();
    apb(1'b1, 12'h000, 32'h44);
    droop <= 1'b1;
    repeat (4) @(posedge i_clk);
    cmp_pin(32'(irq_oe), 32'h0);
    apb(1'b0, 12'h004, 32'h0, 32'h84);
    apb(1'b1, 12'h000, 32'h4);
    droop <= 1'b0;
    repeat (4) @(posedge i_clk);
    cmp_pin(32'(irq_oe), 32'h1);
    clr_irq();
    for (int k = 0; k < 3; k++) begin
      done <= (k == 0);
      rech <= (k == 1);
      thr <= (k == 2);
      repeat (4) @(posedge i_clk);
      cmp_pin(32'(irq_oe), 32'h1);
      apb(1'b0, 12'h004, 32'h0, (k == 2) ? 32'h15 : 32'h0D);
      {done, rech, thr} <= 3'b000;
      clr_irq();
    end
    pmu_en <= 1'b1;
    repeat (6) @(posedge i_clk);
    cmp_pin(32'(bias_en), 32'h1);
    apb(1'b0, 12'h004, 32'h0, 32'h07);
    pmu_en <= 1'b0;
    clr_irq();
    $display("Interrupt and status tests done");
    pack_in <= 1'b1;
    wait_lvl(wake, 1'b1, 500, t);
    cmp_pin(32'(t >= 398 && t <= 415), 32'h1);
    repeat (100) @(posedge i_clk);
    pmu_en <= 1'b1;
    wait_lvl(wake, 1'b0, 800, t);
    cmp_pin(32'(t + 100), 32'h2BC);
    pack_in <= 1'b0;
    repeat (20) @(posedge i_clk);
    pack_in <= 1'b1;
    wait_lvl(wake, 1'b1, 600, t);
    cmp_pin(32'(t), 32'h258);
    $display("Wake pulse tests done");
    foreach (band_tbl[i]) begin
      apb(1'b1, 12'h000, {20'h0, band_tbl[i][20:9]});
      ratio_cmd <= band_tbl[i][8:2];
      repeat (4) @(posedge i_clk);
      cmp_pin(32'({halve, cv_red}), 32'(band_tbl[i][1:0]));
      apb(1'b0, 12'h008, 32'h0, 32'({band_tbl[i][0], band_tbl[i][1], 4'h4}));
    end
    ratio_cmd <= 7'h2D;
    charging <= 1'b1;
    fast <= 1'b1;
    wait_lvl(trickle, 1'b1, 300, t);
    cmp_pin(32'(t >= 35 && t <= 75), 32'h1);
    repeat (2) @(posedge i_clk);
    wait_lvl(chg_oe, 1'b1, 1400, t);
    cmp_pin(32'(t >= 1235 && t <= 1255), 32'h1);
    for (int m = 0; m < 4; m++) begin
      case (m)
        0: vin_plug <= 1'b1;
        1: pmu_en <= 1'b0;
        2: ovp <= 1'b1;
        default: apb(1'b1, 12'h000, 32'h14);
      endcase
      repeat (3) @(posedge i_clk);
      cmp_pin(32'(trickle), 32'h0);
      if (m == 3) cmp_pin(32'({chg_en, chg_oe}), 32'h0);
      if (m == 3) apb(1'b1, 12'h000, 32'h4);
      {vin_plug, ovp} <= 2'b00;
      wait_lvl(trickle, 1'b1, 300, t);
      cmp_pin(32'(trickle), 32'h1);
    end
    cmp_pin(32'(bias_en), 32'h1);
    ratio_cmd <= 7'h37;
    pmu_en <= 1'b1;
    repeat (4) @(posedge i_clk);
    wait_lvl(trickle, 1'b1, 400, t);
    cmp_pin(32'(t >= 80 && t <= 118), 32'h1);
    ratio_cmd <= 7'h2D;
    pmu_en <= 1'b0;
    repeat (34) @(posedge i_clk);
    ratio_cmd <= 7'h50;
    repeat (6) @(posedge i_clk);
    wait_lvl(chg_oe, 1'b1, 10100, t);
    cmp_pin(32'(t >= 9975 && t <= 10005), 32'h1);
    cmp_pin(32'({trickle, chg_en}), 32'h0);
    ratio_cmd <= 7'h2D;
    wait_lvl(trickle, 1'b1, 300, t);
    cmp_pin(32'(t <= 35), 32'h1);
    $display("Fault timer and thermistor tests done");
    tally_and_finish();
  end
endmodule : charger_supervisor_tb
`default_nettype wire
